// file: irq_wake_pkg.sv
// Purpose: Shared constants and types for the interrupt wake and return block
// Assumes: APB register access, 32-bit data, one clock domain (pclk)
// Notes:   Register offsets are byte addresses; each register is one word
`default_nettype none

package irq_wake_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NSRC        = 8;   // Individual request sources
    localparam int NGRP        = 2;   // Grouped (multi-function) requests
    localparam int NDIRECT     = 4;   // Sources with a vector of their own
    localparam int NVEC        = 6;   // Direct vectors followed by group vectors
    localparam int VEC_W       = 3;
    localparam int PC_W        = 16;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W        = 5;
    localparam int SA_W        = 4;
    localparam int ADDR_W      = 8;
    localparam int EVT_W       = 4;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLAG_SET = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STACK    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVT      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_GIE_BIT   = 0;
    localparam int FLAGS_GRP_LSB  = 8;
    localparam int STACK_FULL_BIT = 8;
    localparam int EVT_WAKE       = 0;   // A request flag rose
    localparam int EVT_SERVICE    = 1;   // A vectored call was taken
    localparam int EVT_OVERFLOW   = 2;   // Push refused, stack full
    localparam int EVT_UNDERFLOW  = 3;   // Return refused, stack empty

    // ----------------------------------------------------------------
    // Values after reset and group membership
    // ----------------------------------------------------------------
    localparam logic            GIE_RST    = 1'b0;
    localparam logic [NVEC-1:0] ENABLE_RST = 6'h00;
    localparam logic [EVT_W-1:0] MASK_RST  = 4'h0;
    localparam logic [NGRP-1:0][NSRC-1:0] GRP_MEMBERS = {8'hC0, 8'h30};

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // Commands from the core sequencer, one operation per cycle
    typedef struct packed {
        logic            take;   // Core enters the presented vector
        logic            push;   // Plain subroutine call
        logic            ret;    // Plain return
        logic            return_from_interrupt;   // Return from interrupt
        logic [PC_W-1:0] pc;     // Address to stack on take or push
    } core_cmd_t;

    // Vector presented to the core
    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] idx;
    } vec_req_t;

endpackage

`default_nettype wire

// file: irq_stack_mem.sv
// Purpose: Return address store for the hardware stack
// Assumes: One write or one read per cycle, chosen by the owner
// Notes:   Read data come from a register and hold until the next read
`timescale 1ns/1ps
`default_nettype none

module irq_stack_mem (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            we,
    input  wire logic [irq_wake_pkg::SA_W-1:0]   waddr,
    input  wire logic [irq_wake_pkg::PC_W-1:0]   wdata,
    input  wire logic                            re,
    input  wire logic [irq_wake_pkg::SA_W-1:0]   raddr,
    output logic      [irq_wake_pkg::PC_W-1:0]   rdata_r
);

    logic [irq_wake_pkg::PC_W-1:0] mem [irq_wake_pkg::STACK_DEPTH];

    // Storage array, no reset needed
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 16'h0000;
        end else if (re) begin
            rdata_r <= mem[raddr];
        end
    end

endmodule // irq_stack_mem

`default_nettype wire

// file: irq_wake_return.sv
// Purpose: Request flags, wake-up, vectored call and return control
// Assumes: pclk is the always-on low-speed clock; it runs while the core is halted
// Notes:   Source inputs are pin-level and pass a three-stage synchroniser
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module irq_wake_return (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    // APB slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [irq_wake_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // Peripheral request sources (asynchronous levels)
    input  wire logic [irq_wake_pkg::NSRC-1:0]       src_req,
    // Core sequencer
    input  wire irq_wake_pkg::core_cmd_t             core_cmd,
    output irq_wake_pkg::vec_req_t                   vec_req,
    output logic                                     ret_valid,
    output logic      [irq_wake_pkg::PC_W-1:0]       ret_addr,
    output logic                                     global_irq_enable,
    // System
    output logic                                     wake,
    output logic                                     irq
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Lowest numbered set bit wins
    function automatic logic [irq_wake_pkg::VEC_W-1:0] pick_lowest(
        input logic [irq_wake_pkg::NVEC-1:0] v);
        logic [irq_wake_pkg::VEC_W-1:0] r;
        r = 3'h0;
        for (int i = irq_wake_pkg::NVEC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    localparam int NFLAG = irq_wake_pkg::NSRC + irq_wake_pkg::NGRP;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [irq_wake_pkg::NSRC-1:0]  s1_r, s2_r, s3_r, stable_r, stable_prev_r;
    logic [irq_wake_pkg::NSRC-1:0]  src_flag_r, src_flag_nxt;
    logic [irq_wake_pkg::NGRP-1:0]  grp_flag_r, grp_flag_nxt;
    logic [NFLAG-1:0]               flag_prev_r, flag_rise;
    logic [irq_wake_pkg::NSRC-1:0]  src_event, sw_set_src, sw_clr_src, svc_clr_src;
    logic [irq_wake_pkg::NGRP-1:0]  grp_set, sw_set_grp, sw_clr_grp, svc_clr_grp;
    logic [irq_wake_pkg::NVEC-1:0]  enable_r, vec_flags, eligible;
    logic [irq_wake_pkg::SP_W-1:0]  sp_r;
    logic                           gie_r, stack_full, stack_empty, mem_we;
    logic                           take_go, push_go, pop_go, return_from_interrupt_go, ovf_evt, unf_evt;
    logic [irq_wake_pkg::SA_W-1:0]  mem_waddr, mem_raddr;
    logic [irq_wake_pkg::PC_W-1:0]  mem_wdata;
    logic [irq_wake_pkg::EVT_W-1:0] evt_r, evt_nxt, evt_set, mask_r;
    logic                           pready_r, pslverr_r, irq_r, wake_r, ret_valid_r;
    logic [31:0]                    prdata_r, rd_mux;
    logic                           rd_hit;
    logic                           apb_setup, apb_access, apb_wr, apb_rd;
    irq_wake_pkg::vec_req_t         vec_req_r;

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    // Setup samples the address; the access phase is one cycle long
    assign apb_setup  = psel & ~penable & ~pready_r;
    assign apb_access = psel & penable & pready_r;
    assign apb_wr     = apb_access & pwrite;
    assign apb_rd     = apb_access & ~pwrite;

    // Read multiplexer, evaluated during setup
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            irq_wake_pkg::OFS_CTRL: rd_mux[irq_wake_pkg::CTRL_GIE_BIT] = gie_r;
            irq_wake_pkg::OFS_ENABLE: rd_mux[irq_wake_pkg::NVEC-1:0] = enable_r;
            irq_wake_pkg::OFS_FLAGS: begin
                rd_mux[irq_wake_pkg::NSRC-1:0] = src_flag_r;
                rd_mux[irq_wake_pkg::FLAGS_GRP_LSB +: irq_wake_pkg::NGRP] = grp_flag_r;
            end
            irq_wake_pkg::OFS_FLAG_SET: rd_mux = 32'h0000_0000;
            irq_wake_pkg::OFS_STACK: begin
                rd_mux[irq_wake_pkg::SP_W-1:0]        = sp_r;
                rd_mux[irq_wake_pkg::STACK_FULL_BIT]  = stack_full;
            end
            irq_wake_pkg::OFS_EVT: rd_mux[irq_wake_pkg::EVT_W-1:0] = evt_r;
            irq_wake_pkg::OFS_EVT_MASK: rd_mux[irq_wake_pkg::EVT_W-1:0] = mask_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // Answer registers: ready, data and error come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup & ~rd_hit;
            if (apb_setup) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Software decoded strobes
    assign sw_clr_src = (apb_wr && paddr == irq_wake_pkg::OFS_FLAGS) ?
                        pwdata[irq_wake_pkg::NSRC-1:0] : 8'h00;
    assign sw_clr_grp = (apb_wr && paddr == irq_wake_pkg::OFS_FLAGS) ?
                        pwdata[irq_wake_pkg::FLAGS_GRP_LSB +: irq_wake_pkg::NGRP] : 2'h0;
    assign sw_set_src = (apb_wr && paddr == irq_wake_pkg::OFS_FLAG_SET) ?
                        pwdata[irq_wake_pkg::NSRC-1:0] : 8'h00;
    assign sw_set_grp = (apb_wr && paddr == irq_wake_pkg::OFS_FLAG_SET) ?
                        pwdata[irq_wake_pkg::FLAGS_GRP_LSB +: irq_wake_pkg::NGRP] : 2'h0;

    // Enable and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= irq_wake_pkg::ENABLE_RST;
            mask_r   <= irq_wake_pkg::MASK_RST;
        end else if (apb_wr) begin
            if (paddr == irq_wake_pkg::OFS_ENABLE) begin
                enable_r <= pwdata[irq_wake_pkg::NVEC-1:0];
            end
            if (paddr == irq_wake_pkg::OFS_EVT_MASK) begin
                mask_r <= pwdata[irq_wake_pkg::EVT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Source synchroniser
    // ----------------------------------------------------------------
    // Three stages; a level is accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r          <= 8'h00;
            s2_r          <= 8'h00;
            s3_r          <= 8'h00;
            stable_r      <= 8'h00;
            stable_prev_r <= 8'h00;
        end else begin
            s1_r          <= src_req;
            s2_r          <= s1_r;
            s3_r          <= s2_r;
            stable_r      <= (s2_r & s3_r) | (stable_r & (s2_r | s3_r));
            stable_prev_r <= stable_r;
        end
    end

    assign src_event = stable_r & ~stable_prev_r;

    // ----------------------------------------------------------------
    // Request flags
    // ----------------------------------------------------------------
    // One-clock-earlier compare
    assign flag_rise = {grp_flag_r, src_flag_r} & ~flag_prev_r;

    always_comb begin
        for (int g = 0; g < irq_wake_pkg::NGRP; g++) begin
            grp_set[g] = |(flag_rise[irq_wake_pkg::NSRC-1:0] & irq_wake_pkg::GRP_MEMBERS[g]);
        end
    end

    // Flags latch; set wins over clear
    assign src_flag_nxt = (src_flag_r & ~sw_clr_src & ~svc_clr_src) | src_event | sw_set_src;
    assign grp_flag_nxt = (grp_flag_r & ~sw_clr_grp & ~svc_clr_grp) | grp_set | sw_set_grp;

    // Flag storage and the previous-value copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_flag_r  <= 8'h00;
            grp_flag_r  <= 2'h0;
            flag_prev_r <= 10'h000;
        end else begin
            src_flag_r  <= src_flag_nxt;
            grp_flag_r  <= grp_flag_nxt;
            flag_prev_r <= {grp_flag_r, src_flag_r};
        end
    end

    // ----------------------------------------------------------------
    // Wake-up
    // ----------------------------------------------------------------
    // Rise of any flag, enables not consulted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= |flag_rise;
        end
    end

    // ----------------------------------------------------------------
    // Vector selection
    // ----------------------------------------------------------------
    assign vec_flags   = {grp_flag_r, src_flag_r[irq_wake_pkg::NDIRECT-1:0]};
    assign eligible    = vec_flags & enable_r;
    assign stack_full  = (sp_r == 5'(irq_wake_pkg::STACK_DEPTH));
    assign stack_empty = (sp_r == 5'h00);

    // Enabled, pending and room on the stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_req_r <= '0;
        end else begin
            vec_req_r.valid <= gie_r & (|eligible) & ~stack_full & ~take_go;
            vec_req_r.idx   <= pick_lowest(eligible);
        end
    end

    // ----------------------------------------------------------------
    // Stack operations
    // ----------------------------------------------------------------
    // One operation per cycle: take, then push, then return
    assign take_go = core_cmd.take & vec_req_r.valid;
    assign push_go = ~take_go & core_cmd.push & ~stack_full;
    assign pop_go  = ~take_go & ~core_cmd.push & (core_cmd.ret | core_cmd.return_from_interrupt) & ~stack_empty;
    assign return_from_interrupt_go = pop_go & core_cmd.return_from_interrupt;
    assign ovf_evt = ~take_go & core_cmd.push & stack_full;
    assign unf_evt = ~take_go & ~core_cmd.push & (core_cmd.ret | core_cmd.return_from_interrupt) & stack_empty;

    // Only the program counter is stacked
    assign mem_we    = take_go | push_go;
    assign mem_wdata = core_cmd.pc;
    assign mem_waddr = sp_r[irq_wake_pkg::SA_W-1:0];
    assign mem_raddr = 4'(sp_r - 5'h01);

    // Service clears only the vector's own flag
    always_comb begin
        svc_clr_src = 8'h00;
        svc_clr_grp = 2'h0;
        if (take_go) begin
            if (vec_req_r.idx < 3'(irq_wake_pkg::NDIRECT)) begin
                svc_clr_src[vec_req_r.idx] = 1'b1;
            end else begin
                svc_clr_grp[1'(vec_req_r.idx - 3'(irq_wake_pkg::NDIRECT))] = 1'b1;
            end
        end
    end

    // Stack pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= 5'h00;
        end else if (mem_we) begin
            sp_r <= sp_r + 5'h01;
        end else if (pop_go) begin
            sp_r <= sp_r - 5'h01;
        end
    end

    // Return strobe, aligned with the registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_valid_r <= 1'b0;
        end else begin
            ret_valid_r <= pop_go;
        end
    end

    irq_stack_mem u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .re      (pop_go),
        .raddr   (mem_raddr),
        .rdata_r (ret_addr)
    );

    // ----------------------------------------------------------------
    // Global interrupt enable
    // ----------------------------------------------------------------
    // Cleared on service; set by interrupt return
    // A plain return leaves it untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r <= irq_wake_pkg::GIE_RST;
        end else if (return_from_interrupt_go) begin
            gie_r <= 1'b1;
        end else if (take_go) begin
            gie_r <= 1'b0;
        end else if (apb_wr && paddr == irq_wake_pkg::OFS_CTRL) begin
            gie_r <= pwdata[irq_wake_pkg::CTRL_GIE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Event status and interrupt line
    // ----------------------------------------------------------------
    // Sticky events; a read clears only what it returned, a new event wins
    always_comb begin
        evt_set = 4'h0;
        evt_set[irq_wake_pkg::EVT_WAKE]      = |flag_rise;
        evt_set[irq_wake_pkg::EVT_SERVICE]   = take_go;
        evt_set[irq_wake_pkg::EVT_OVERFLOW]  = ovf_evt;
        evt_set[irq_wake_pkg::EVT_UNDERFLOW] = unf_evt;
        evt_nxt = evt_r;
        if (apb_rd && paddr == irq_wake_pkg::OFS_EVT) begin
            evt_nxt = evt_r & ~prdata_r[irq_wake_pkg::EVT_W-1:0];
        end
        evt_nxt = evt_nxt | evt_set;
    end

    // Event register and level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_r <= 4'h0;
            irq_r <= 1'b0;
        end else begin
            evt_r <= evt_nxt;
            irq_r <= |(evt_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign vec_req           = vec_req_r;
    assign ret_valid         = ret_valid_r;
    assign global_irq_enable = gie_r;
    assign wake              = wake_r;
    assign irq               = irq_r;

endmodule // irq_wake_return

`default_nettype wire

// file: irq_wake_return_asserts.sv
// Purpose: Port assertions for the wake and return block
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module irq_wake_return_asserts (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire irq_wake_pkg::core_cmd_t core_cmd,
    input wire irq_wake_pkg::vec_req_t  vec_req,
    input wire logic                    ret_valid,
    input wire logic [15:0]             ret_addr,
    input wire logic                    global_irq_enable
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence call_s; core_cmd.take && vec_req.valid; endsequence
    sequence pop_s(logic r); r && !core_cmd.take && !core_cmd.push; endsequence
    take_clears_gie_a: assert property (call_s |=> !global_irq_enable)
        else $error("enable still set after vectored call");
    take_drops_vec_a: assert property (call_s |=> !vec_req.valid)
        else $error("vector still offered after call");
    return_from_interrupt_sets_gie_a: assert property (pop_s(core_cmd.return_from_interrupt) ##1 ret_valid |-> global_irq_enable)
        else $error("enable low after interrupt return");
    ret_keeps_gie_a: assert property (pop_s(core_cmd.ret && !core_cmd.return_from_interrupt
        && !(psel && penable && pwrite)) |=> $stable(global_irq_enable))
        else $error("plain return changed the enable");
    vec_needs_gie_a: assert property (!global_irq_enable ##1 !global_irq_enable
        |-> !vec_req.valid)
        else $error("vector offered with enable low");
    vec_idx_range_a: assert property (vec_req.valid |-> vec_req.idx < irq_wake_pkg::NVEC)
        else $error("vector index out of range");
    ret_has_cause_a: assert property (ret_valid |-> $past(core_cmd.ret || core_cmd.return_from_interrupt))
        else $error("return data without a return command");
    pending_holds_a: assert property (vec_req.valid && !core_cmd.take && !core_cmd.push
        && !psel && !$past(psel) |=> vec_req.valid)
        else $error("pending request dropped without service");
    addr_holds_a: assert property (!ret_valid |-> $stable(ret_addr))
        else $error("return address moved without a pop");
endmodule // irq_wake_return_asserts
`default_nettype wire

// file: core_seq_model.sv
// Purpose: Core sequencer model that enters offered vectors
// Assumes: Bench supplies push, return and pc through tb_cmd
// Notes:   auto_take low lets the bench stall vector entry
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    auto_take,
    input  wire irq_wake_pkg::vec_req_t  vec_req,
    input  wire irq_wake_pkg::core_cmd_t tb_cmd,
    output var  irq_wake_pkg::core_cmd_t core_cmd
);
    logic take_r;
    // no nested calls: enter one cycle after offer, never twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_r <= 1'b0;
        end else begin
            take_r <= vec_req.valid && auto_take && !take_r;
        end
    end
    // Merge the entry pulse into the bench commands
    always_comb begin
        core_cmd = tb_cmd;
        core_cmd.take = take_r;
    end
endmodule // core_seq_model
`default_nettype wire

// file: test_irq_wake_return.sv
// Purpose: Self-checking bench for the wake and return block
// Assumes: 50 MHz pclk, APB master tasks, core model as partner
// Notes:   Source order and return address drawn from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module test_irq_wake_return;
    logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                    ret_valid, global_irq_enable, wake, irq, auto_take;
    logic [7:0]              paddr, src_req;
    logic [31:0]             pwdata, prdata, rdat;
    logic [15:0]             ret_addr, p;
    logic [2:0]              j, off;
    irq_wake_pkg::core_cmd_t core_cmd, tb_cmd;
    irq_wake_pkg::vec_req_t  vec_req;
    int                      fails, comparisons, wakes, w0, k, seed;
    irq_wake_return dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_req, .core_cmd, .vec_req, .ret_valid, .ret_addr,
        .global_irq_enable, .wake, .irq);
    core_seq_model core (.pclk, .presetn, .auto_take, .vec_req, .tb_cmd, .core_cmd);
    // ------------------------------------------------------------
    // Clock, wake counter, watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) if (wake === 1'b1) wakes <= wakes + 1;
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    function automatic logic [31:0] exp_flags(input logic [2:0] s);
        exp_flags = 32'h1 << s;
        if (s[2]) exp_flags |= 32'h100 << (s[2:1] - 2'h2);
    endfunction
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, src_req, auto_take} = '0;
        {tb_cmd, fails, comparisons, wakes, presetn} = '0;
        seed = 32'h79B7;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(irq_wake_pkg::OFS_CTRL, 32'h0);
        rd(irq_wake_pkg::OFS_ENABLE, 32'h0);
        rd(8'h1C, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, irq_wake_pkg::OFS_EVT_MASK, 32'h1);
        off = 3'($random(seed));
        // Every source rises once while all enables are low
        for (k = 0; k < 8; k++) begin
            j = 3'(k) + off;
            w0 = wakes;
            src_req[j] <= 1'b1;
            repeat (12 + ($random(seed) & 3)) @(posedge pclk);
            chk(wakes - w0, j[2] ? 2 : 1);
            rd(irq_wake_pkg::OFS_FLAGS, exp_flags(j));
            chk(irq, 1'b1);
            rd(irq_wake_pkg::OFS_EVT, 32'h1);
            rd(irq_wake_pkg::OFS_EVT, 32'h0);
            src_req[j] <= 1'b0;
            apb(1'b1, irq_wake_pkg::OFS_FLAGS, 32'h3FF);
            chk(irq, 1'b0);
        end
        // Flag set beforehand suppresses the wake; disabled flag stays latched
        apb(1'b1, irq_wake_pkg::OFS_EVT_MASK, 32'h0);
        apb(1'b1, irq_wake_pkg::OFS_FLAG_SET, 32'h1);
        repeat (4) @(posedge pclk);
        w0 = wakes;
        src_req[0] <= 1'b1;
        repeat (12) @(posedge pclk);
        chk(wakes - w0, 0);
        chk(irq, 1'b0);
        apb(1'b1, irq_wake_pkg::OFS_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        chk(vec_req.valid, 1'b0);
        rd(irq_wake_pkg::OFS_FLAGS, 32'h1);
        src_req[0] <= 1'b0;
        apb(1'b1, irq_wake_pkg::OFS_FLAGS, 32'h3FF);
        // Group service, then interrupt return and plain return
        p = 16'($random(seed));
        tb_cmd.pc <= p;
        auto_take <= 1'b1;
        apb(1'b1, irq_wake_pkg::OFS_ENABLE, 32'h10);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, irq_wake_pkg::OFS_FLAG_SET, 32'h20);
            repeat (8) @(posedge pclk);
            chk(global_irq_enable, 1'b0);
            rd(irq_wake_pkg::OFS_FLAGS, 32'h20);
            rd(irq_wake_pkg::OFS_STACK, 32'h1);
            {tb_cmd.return_from_interrupt, tb_cmd.ret} <= (k == 0) ? 2'b10 : 2'b01;
            @(posedge pclk);
            {tb_cmd.return_from_interrupt, tb_cmd.ret} <= 2'b00;
            @(posedge pclk);
            chk(ret_valid, 1'b1);
            chk(ret_addr, p);
            chk(global_irq_enable, k == 0);
            apb(1'b1, irq_wake_pkg::OFS_FLAGS, 32'h3FF);
            apb(1'b1, irq_wake_pkg::OFS_CTRL, 32'h1);
        end
        // Full stack blocks the call until one level is freed
        auto_take <= 1'b0;
        tb_cmd.push <= 1'b1;
        repeat (16) @(posedge pclk);
        tb_cmd.push <= 1'b0;
        rd(irq_wake_pkg::OFS_STACK, 32'h110);
        apb(1'b1, irq_wake_pkg::OFS_FLAG_SET, 32'h20);
        repeat (6) @(posedge pclk);
        chk(vec_req.valid, 1'b0);
        tb_cmd.ret <= 1'b1;
        @(posedge pclk);
        tb_cmd.ret <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(vec_req.valid, 1'b1);
        complete_run();
    end
endmodule // test_irq_wake_return
bind irq_wake_return irq_wake_return_asserts chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .core_cmd, .vec_req, .ret_valid, .ret_addr, .global_irq_enable);
`default_nettype wire
